//--- hdl/ccms_top.sv
// Core clock mode selector: strap capture, source select, watchdog
`include "ccms_defines.svh"
module ccms_top
	import ccms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [2:0] clock_mode_straps,
	input wire logic clock_input_pin,
	input wire logic pll_clk,
	input wire logic osc_watchdog_disable,
	output logic core_clk_q,
	output logic core_rise_q,
	output logic core_fall_q,
	output logic pll_enable_q,
	output logic [`CCMS_FACTOR_W-1:0] pll_factor_q,
	output logic osc_amp_en_q,
	output logic owd_irq_q,
	output logic clk_fail_q,
	output logic [2:0] mode_q
);

	// Multiplication factor for a code; none for the prescaler code, factor 1 for direct drive
	function automatic logic [`CCMS_FACTOR_W-1:0] factor_of(
		input ccms_code_t code);
		case (code)
			`CCMS_CODE_X4: factor_of = `CCMS_FACTOR_4;
			`CCMS_CODE_X3: factor_of = `CCMS_FACTOR_3;
			`CCMS_CODE_X8: factor_of = `CCMS_FACTOR_8;
			`CCMS_CODE_X5: factor_of = `CCMS_FACTOR_5;
			`CCMS_CODE_DIRECT: factor_of = `CCMS_FACTOR_1;
			`CCMS_CODE_X10: factor_of = `CCMS_FACTOR_10;
			`CCMS_CODE_PRESC: factor_of = `CCMS_FACTOR_NONE;
			default: factor_of = `CCMS_FACTOR_16;
		endcase
	endfunction

	function automatic ccms_state_e state_of(input ccms_code_t code);
		if (code == `CCMS_CODE_DIRECT)
			state_of = CCMS_ST_DIRECT;
		else if (code == `CCMS_CODE_PRESC)
			state_of = CCMS_ST_PRESC;
		else
			state_of = CCMS_ST_PLL;
	endfunction

	ccms_state_e state_q;
	ccms_state_e state_d;
	logic pin_q;
	logic pll_q;
	logic core_d;
	logic pll_en_d;
	logic owd_ovf;

	wire pin_edge = clock_input_pin ^ pin_q;
	wire pin_rise = clock_input_pin & ~pin_q;
	wire pll_rise = pll_clk & ~pll_q;
	wire plain_mode = (state_q == CCMS_ST_DIRECT) ||
		(state_q == CCMS_ST_PRESC);
	wire owd_run = plain_mode && !osc_watchdog_disable;
	wire core_rise_d = core_d & ~core_clk_q;
	wire core_fall_d = ~core_d & core_clk_q;

	ccms_owd_cnt #(
		.LIMIT(`CCMS_OWD_LIMIT),
		.CNT_W(`CCMS_OWD_CNT_W)
	) u_owd (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.run(owd_run),
		.clr(pin_edge),
		.tick(pll_rise),
		.ovf_q(owd_ovf)
	);

	always_comb
	begin
		state_d = state_q;
		core_d = core_clk_q;
		pll_en_d = 1'b1;
		case (state_q)
			CCMS_ST_PLL:
			begin
				core_d = pll_clk;
			end
			CCMS_ST_DIRECT:
			begin
				core_d = clock_input_pin;
				pll_en_d = !osc_watchdog_disable;
				if (owd_ovf)
					state_d = CCMS_ST_FAIL;
			end
			CCMS_ST_PRESC:
			begin
				// One toggle per input period: each phase is one period
				if (pin_rise)
					core_d = ~core_clk_q;
				pll_en_d = !osc_watchdog_disable;
				if (owd_ovf)
					state_d = CCMS_ST_FAIL;
			end
			CCMS_ST_FAIL:
			begin
				core_d = pll_clk;
			end
			default:
			begin
				state_d = CCMS_ST_PLL;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			if (ce)
			begin
				mode_q <= clock_mode_straps;
				state_q <= state_of(clock_mode_straps);
			end
			pin_q <= 1'b0;
			pll_q <= 1'b0;
			core_clk_q <= 1'b0;
			core_rise_q <= 1'b0;
			core_fall_q <= 1'b0;
			pll_enable_q <= 1'b0;
			pll_factor_q <= `CCMS_FACTOR_NONE;
			osc_amp_en_q <= 1'b1;
			owd_irq_q <= 1'b0;
			clk_fail_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			pin_q <= clock_input_pin;
			pll_q <= pll_clk;
			core_clk_q <= core_d;
			core_rise_q <= core_rise_d;
			core_fall_q <= core_fall_d;
			pll_enable_q <= pll_en_d;
			pll_factor_q <= factor_of(mode_q);
			// Bypass follows the captured code, also after a clock fail
			osc_amp_en_q <= (mode_q != `CCMS_CODE_DIRECT);
			owd_irq_q <= owd_ovf;
			clk_fail_q <= clk_fail_q | owd_ovf;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence ovf_seen_s;
		owd_ovf && ce;
	endsequence

	sequence switched_s;
		owd_irq_q && clk_fail_q && state_q == CCMS_ST_FAIL;
	endsequence

	strap_latch_a: assert property (
		disable iff (1'b0) (!nrst && ce) |=>
		mode_q == $past(clock_mode_straps))
		else $error("strap code not captured in reset");

	strap_hold_a: assert property (
		$past(nrst) |-> $stable(mode_q))
		else $error("mode code changed after reset");

	pll_factor_a: assert property (
		(ce && mode_q == `CCMS_CODE_X10) |=>
		pll_factor_q == `CCMS_FACTOR_10)
		else $error("wrong factor for code 010");

	pll_mode_a: assert property (
		(ce && state_q == CCMS_ST_PLL) |=>
		pll_enable_q && core_clk_q == $past(pll_clk))
		else $error("pll mode not driven by pll");

	presc_toggle_a: assert property (
		(ce && state_q == CCMS_ST_PRESC && !owd_ovf &&
		clock_input_pin && !pin_q) |=>
		core_clk_q != $past(core_clk_q))
		else $error("prescaler missed an input rise");

	presc_hold_a: assert property (
		(ce && state_q == CCMS_ST_PRESC && !(clock_input_pin && !pin_q))
		|=> $stable(core_clk_q))
		else $error("prescaler toggled without input rise");

	direct_follow_a: assert property (
		(ce && state_q == CCMS_ST_DIRECT) |=>
		core_clk_q == $past(clock_input_pin) && !osc_amp_en_q)
		else $error("direct drive does not follow input");

	owd_pll_a: assert property (
		(ce && plain_mode) |=>
		pll_enable_q == !$past(osc_watchdog_disable))
		else $error("pll enable wrong in plain mode");

	edge_strobe_a: assert property (
		ce ##1 core_rise_q |-> core_clk_q && !$past(core_clk_q))
		else $error("rise strobe without a rising edge");

	fall_strobe_a: assert property (
		ce ##1 core_fall_q |-> !core_clk_q && $past(core_clk_q))
		else $error("fall strobe without a falling edge");

	amp_bypass_a: assert property (
		(ce && mode_q == `CCMS_CODE_DIRECT) |=> !osc_amp_en_q)
		else $error("amplifier enabled in direct drive");

	irq_pulse_a: assert property (
		(owd_irq_q && ce) |=> !owd_irq_q)
		else $error("watchdog request longer than one cycle");

	owd_switch_a: assert property (
		ovf_seen_s |=> switched_s)
		else $error("overflow did not switch the clock");

	fail_sticky_a: assert property (
		clk_fail_q |=> clk_fail_q && state_q == CCMS_ST_FAIL)
		else $error("clock fail left before reset");

endmodule // ccms_top

//--- hdl/ccms_defines.svh
// Constants of the core clock mode selector
// Notes on behaviour
// - Strap code on the three clock mode inputs is captured while reset is held and picks the core clock source.
// - Codes 111 x4 (default), 110 x3, 101 x8, 100 x5, 011 x1, 010 x10, 001 half, 000 x16.
// - Code 001 makes the core clock the input clock divided by two, without the PLL.
// - In prescaler mode each core clock high and low phase lasts one input clock period.
// - Code 011 bypasses the oscillator amplifier and drives the core clock from the input pin; the PLL stays on unless the watchdog disable bit is set.
// - In direct drive the core clock follows the input duty cycle, so two half-cycles make one input period.
// - In prescaler or direct drive the PLL free-runs for the oscillator watchdog unless the disable bit is set.
// - Both core clock edges are offered to internal logic, each half-cycle being a timing unit.
// - Every other code enables the PLL and takes the core clock from its output at the chosen factor.
// - The oscillator watchdog is on after reset and the disable bit (bit four of the system config register) turns it off.
// - The watchdog counts PLL cycles, clears on each input transition, and at 16 switches the core clock to the PLL until reset and pulses an interrupt.
`ifndef CCMS_DEFINES_SVH
`define CCMS_DEFINES_SVH

`define CCMS_CODE_X4 3'h7
`define CCMS_CODE_X3 3'h6
`define CCMS_CODE_X8 3'h5
`define CCMS_CODE_X5 3'h4
`define CCMS_CODE_DIRECT 3'h3
`define CCMS_CODE_X10 3'h2
`define CCMS_CODE_PRESC 3'h1
`define CCMS_CODE_X16 3'h0

`define CCMS_FACTOR_W 5
`define CCMS_FACTOR_NONE 5'h00
`define CCMS_FACTOR_1 5'h01
`define CCMS_FACTOR_3 5'h03
`define CCMS_FACTOR_4 5'h04
`define CCMS_FACTOR_5 5'h05
`define CCMS_FACTOR_8 5'h08
`define CCMS_FACTOR_10 5'h0A
`define CCMS_FACTOR_16 5'h10

`define CCMS_OWD_LIMIT 16
`define CCMS_OWD_CNT_W 5

`endif

//--- hdl/ccms_pkg.sv
// Types of the core clock mode selector
package ccms_pkg;

	typedef logic [2:0] ccms_code_t;

	typedef enum logic [3:0] {
		CCMS_ST_PLL = 4'h1,
		CCMS_ST_DIRECT = 4'h2,
		CCMS_ST_PRESC = 4'h4,
		CCMS_ST_FAIL = 4'h8
	} ccms_state_e;

endpackage

//--- hdl/ccms_owd_cnt.sv
// Oscillator watchdog counter, PLL ticks cleared by input transitions
`include "ccms_defines.svh"
module ccms_owd_cnt #(
	parameter int LIMIT = `CCMS_OWD_LIMIT,
	parameter int CNT_W = `CCMS_OWD_CNT_W
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic clr,
	input wire logic tick,
	output logic ovf_q
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic ovf_d;
	wire at_last = (cnt_q == LAST);

	// Input transition wins over a PLL tick
	assign ovf_d = run && !clr && tick && at_last;
	assign cnt_d = (!run || clr || ovf_d) ? '0 :
		(tick ? cnt_q + 1'b1 : cnt_q);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end
		else if (ce)
		begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
	end

endmodule // ccms_owd_cnt

//--- sim/ccms_xtal_model.sv
// External clock source and free-running PLL model
module ccms_xtal_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic run,
	input wire logic pll_on,
	input wire logic [3:0] half,
	output logic pin,
	output logic pll
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial pin = 1'b0;
	initial pll = 1'b0;
	always @(posedge clk_sys)
	begin
		cnt = cnt + 1;
		if (!nrst)
		begin
			cnt = 0;
			pin <= 1'b0;
		end
		// Failed source holds its last level
		else if (run && cnt >= half)
		begin
			cnt = 0;
			pin <= ~pin;
		end
		pll <= pll_on ? ~pll : 1'b0;
	end
endmodule // ccms_xtal_model

//--- sim/tb_cpu_clock_mode_select.sv
// Self-checking bench of the core clock mode selector
`include "ccms_defines.svh"
`define CHK(a, e) \
	begin \
		total_checks++; \
		if ((a) !== (e)) \
		begin \
			fail_count++; \
			$display("unexpected at %0t: %h vs %h", $time, (a), (e)); \
		end \
	end
module tb_cpu_clock_mode_select;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, nrst = 0, ce = 1, dis = 0, run = 1, pin, pll;
	logic [2:0] straps = 3'h0;
	logic [3:0] half = 4'h3;
	logic core_clk_q, core_rise_q, core_fall_q, pll_enable_q;
	logic osc_amp_en_q, owd_irq_q, clk_fail_q;
	logic [4:0] pll_factor_q;
	logic [2:0] mode_q;
	logic e_clk, e_rise, e_fall, e_irq, e_fail, ovf, pp, ppl, old;
	logic [4:0] fac [8] = '{5'h10, 5'h00, 5'h0A, 5'h01,
		5'h05, 5'h08, 5'h03, 5'h04};
	int mode = 0, cnt, mask, fail_count = 0, total_checks = 0;
	integer seed = 24;
	always #20 clk_sys = ~clk_sys;
	ccms_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.clock_mode_straps(straps), .clock_input_pin(pin), .pll_clk(pll),
		.osc_watchdog_disable(dis), .core_clk_q(core_clk_q),
		.core_rise_q(core_rise_q), .core_fall_q(core_fall_q),
		.pll_enable_q(pll_enable_q), .pll_factor_q(pll_factor_q),
		.osc_amp_en_q(osc_amp_en_q), .owd_irq_q(owd_irq_q),
		.clk_fail_q(clk_fail_q), .mode_q(mode_q));
	ccms_xtal_model src_u (.clk_sys(clk_sys), .nrst(nrst), .run(run),
		.pll_on(pll_enable_q), .half(half), .pin(pin), .pll(pll));
	// Reference model, reads inputs as sampled at this edge
	always @(posedge clk_sys)
		if (!nrst)
		begin
			{e_clk, e_rise, e_fall, e_irq, e_fail, ovf, pp, ppl} = '0;
			cnt = 0;
			mask = 0;
		end
		else if (ce)
		begin
			old = e_clk;
			if (mask > 0)
				mask--;
			if (e_fail || !(mode inside {1, 3}))
				e_clk = pll;
			else if (mode == 3)
				e_clk = pin;
			else if (pin && !pp)
				e_clk = ~e_clk;
			e_rise = e_clk & ~old;
			e_fall = old & ~e_clk;
			e_irq = ovf;
			if (ovf)
			begin
				e_fail = 1'b1;
				mask = 2;
			end
			ovf = 1'b0;
			if (mode inside {1, 3} && !dis && !e_fail)
			begin
				if (pin != pp)
					cnt = 0;
				else if (pll && !ppl)
					cnt++;
			end
			if (cnt == `CCMS_OWD_LIMIT)
			begin
				ovf = 1'b1;
				cnt = 0;
			end
			pp = pin;
			ppl = pll;
		end
	always @(negedge clk_sys)
		if (nrst)
		begin
			if (mask == 0)
			begin
				`CHK(core_clk_q, e_clk)
				`CHK(core_rise_q, e_rise)
				`CHK(core_fall_q, e_fall)
			end
			if (!e_fail || e_irq)
				`CHK(owd_irq_q, e_irq)
			`CHK(clk_fail_q, e_fail)
		end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		for (int c = 0; c < 16; c++)
		begin
			nrst <= 1'b0;
			ce <= 1'b1;
			run <= 1'b1;
			mode <= c % 8;
			dis <= c >= 8;
			straps <= 3'(c % 8);
			half <= 4'(2 + ($random(seed) & 3));
			repeat (10) @(posedge clk_sys);
			nrst <= 1'b1;
			for (int i = 0; i < 260; i++)
			begin
				@(posedge clk_sys);
				ce <= ($random(seed) & 7) != 0;
				straps <= 3'($random(seed));
				if (i == 160)
					run <= 1'b0;
			end
			@(negedge clk_sys);
			`CHK(mode_q, 3'(mode))
			`CHK(pll_factor_q, fac[mode])
			`CHK(osc_amp_en_q, 1'(mode != 3))
			`CHK(pll_enable_q, 1'(!(mode inside {1, 3}) || !dis))
			`CHK(clk_fail_q, 1'(mode inside {1, 3} && !dis))
			@(posedge clk_sys);
		end
		finish_test;
	end
endmodule // tb_cpu_clock_mode_select
